//--- hdl/window_defs.svh
// register offsets, field positions and fixed window bounds of the translation unit
`ifndef WINDOW_DEFS_SVH
`define WINDOW_DEFS_SVH
`define OFF_MIN_GRANT     8'h00
`define OFF_MAX_LATENCY   8'h04
`define OFF_LIMIT_0       8'h08
`define OFF_BASE_0        8'h0C
`define OFF_XLATE_0       8'h10
`define OFF_LIMIT_1       8'h14
`define OFF_BASE_1        8'h18
`define OFF_LIMIT_2       8'h1C
`define OFF_BASE_2        8'h20
`define OFF_XLATE_2       8'h24
`define OFF_ROM_LIMIT     8'h28
`define OFF_ROM_BASE      8'h2C
`define OFF_ROM_XLATE     8'h30
`define OFF_OUT_IO_XLATE  8'h34
`define OFF_OUT_MEM_XLATE 8'h38
`define WIN_MASK_LOW      32'hFFFFF000
`define OUT_IO_BASE       32'h90000000
`define OUT_IO_MASK       32'hFFFF0000
`define OUT_MEM_BASE      32'h80000000
`define OUT_MEM_MASK      32'hFC000000
`define MIN_GRANT_VALUE   8'h00
`define MAX_LATENCY_VALUE 8'h00
`define ZERO_WORD         32'h00000000
`endif

//--- hdl/window_pkg.sv
// types shared by the translation unit
package window_pkg;
    typedef enum logic [1:0] {
        in_none,
        in_win0,
        in_win2,
        in_rom
    } inbound_hit_t;
    typedef enum logic [1:0] {
        out_none,
        out_mem,
        out_io
    } outbound_hit_t;
endpackage

//--- hdl/translation_unit.sv
// inbound and outbound address window translation with its configuration registers
`timescale 1ns/1ns
`include "window_defs.svh"

// Behaviour
// - Min grant register reads a fixed value in units of 8 PCI clocks.
// - Max latency register reads a fixed value in units of 8 PCI clocks.
// - Inbound window 0 hits convert PCI address to internal address.
// - Window 2 translates like window 0 with its own limit and translate.
// - Limit bits 31..12 make matching base bits writable, else read zero.
// - An all-zero limit makes base writes have no effect, reading zero.
// - Limit masks translate value bits below window size during translation.
// - Limit sets the size reported when base is sized with all ones.
// - Window 1 is never claimed and never translated.
// - ROM limit gates writable ROM base bits like window limits.
// - ROM window hits drive internal address from ROM translate value.
// - Windows 0 and 2 drive internal address from their translate value.
// - Internal 9000_0000..9000_FFFF is a 64 KB outbound PCI I/O window.
// - Outbound hits drive PCI address from that window's translate value.
// - Internal 8000_0000..83FF_FFFF is a 64 MB outbound memory window.
module translation_unit
    import window_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        in_valid,
    input  wire logic [31:0] in_pci_addr,
    output logic             in_claim,
    output logic [1:0]       in_window,
    output logic [31:0]      in_internal_addr,
    input  wire logic        out_valid,
    input  wire logic [31:0] out_internal_addr,
    output logic             out_claim,
    output logic             out_is_io,
    output logic [31:0]      out_pci_addr
);

    typedef struct packed {
        logic [31:0] limit_0;
        logic [31:0] base_0;
        logic [31:0] xlate_0;
        logic [31:0] limit_1;
        logic [31:0] base_1;
        logic [31:0] limit_2;
        logic [31:0] base_2;
        logic [31:0] xlate_2;
        logic [31:0] rom_limit;
        logic [31:0] rom_base;
        logic [31:0] rom_xlate;
        logic [31:0] out_io_xlate;
        logic [31:0] out_mem_xlate;
        logic [31:0] rdata;
        logic        in_claim;
        logic [1:0]  in_window;
        logic [31:0] in_addr;
        logic        out_claim;
        logic        out_is_io;
        logic [31:0] out_addr;
    } state_t;

    state_t state_q;
    state_t state_d;

    // only bits 31..12 of a limit are meaningful
    function automatic logic [31:0] limit_mask(
        input logic [31:0] limit
    );
        limit_mask = limit & `WIN_MASK_LOW;
    endfunction

    // a base write keeps only bits the limit opens; zero limit blocks all
    function automatic logic [31:0] gated_base(
        input logic [31:0] wdata,
        input logic [31:0] limit
    );
        gated_base = wdata & limit_mask(limit);
    endfunction

    // closing a limit bit drops the base bit it no longer opens
    function automatic logic [31:0] closed_base(
        input logic [31:0] base,
        input logic [31:0] limit
    );
        closed_base = base & limit_mask(limit);
    endfunction

    function automatic logic window_hit(
        input logic [31:0] addr,
        input logic [31:0] base,
        input logic [31:0] limit
    );
        logic [31:0] m;
        m = limit_mask(limit);
        window_hit = ((addr & m) == (base & m)) && ((base & m) != `ZERO_WORD);
    endfunction

    // translate bits under the window size are ignored, offset passes through
    function automatic logic [31:0] translate(
        input logic [31:0] addr,
        input logic [31:0] xlate,
        input logic [31:0] limit
    );
        logic [31:0] m;
        m = limit_mask(limit);
        translate = (xlate & m) | (addr & ~m);
    endfunction

    function automatic logic fixed_hit(
        input logic [31:0] addr,
        input logic [31:0] base,
        input logic [31:0] mask
    );
        fixed_hit = (addr & mask) == base;
    endfunction

    // plain addition: an unaligned translate value carries into the upper bits
    function automatic logic [31:0] fixed_translate(
        input logic [31:0] addr,
        input logic [31:0] xlate,
        input logic [31:0] mask
    );
        fixed_translate = xlate + (addr & ~mask);
    endfunction

    function automatic logic [31:0] info_word(
        input logic [7:0] value
    );
        info_word = {24'h000000, value};
    endfunction

    // one register write; a limit write also clears the base bits it closes
    function automatic state_t apply_write(
        input state_t      s,
        input logic [7:0]  addr,
        input logic [31:0] data
    );
        state_t n;
        n = s;
        case (addr)
            `OFF_LIMIT_0: begin
                n.limit_0 = data;
                n.base_0  = closed_base(s.base_0, data);
            end
            `OFF_BASE_0: begin
                n.base_0 = gated_base(data, s.limit_0);
            end
            `OFF_XLATE_0: begin
                n.xlate_0 = data;
            end
            `OFF_LIMIT_1: begin
                n.limit_1 = data;
                n.base_1  = closed_base(s.base_1, data);
            end
            `OFF_BASE_1: begin
                n.base_1 = gated_base(data, s.limit_1);
            end
            `OFF_LIMIT_2: begin
                n.limit_2 = data;
                n.base_2  = closed_base(s.base_2, data);
            end
            `OFF_BASE_2: begin
                n.base_2 = gated_base(data, s.limit_2);
            end
            `OFF_XLATE_2: begin
                n.xlate_2 = data;
            end
            `OFF_ROM_LIMIT: begin
                n.rom_limit = data;
                n.rom_base  = closed_base(s.rom_base, data);
            end
            `OFF_ROM_BASE: begin
                n.rom_base = gated_base(data, s.rom_limit);
            end
            `OFF_ROM_XLATE: begin
                n.rom_xlate = data;
            end
            `OFF_OUT_IO_XLATE: begin
                n.out_io_xlate = data;
            end
            `OFF_OUT_MEM_XLATE: begin
                n.out_mem_xlate = data;
            end
            // read-only and unmapped offsets swallow the write
            default: begin
                n = s;
            end
        endcase
        apply_write = n;
    endfunction

    // read mux; unmapped offsets read zero
    function automatic logic [31:0] read_word(
        input state_t     s,
        input logic [7:0] addr
    );
        case (addr)
            `OFF_MIN_GRANT: begin
                read_word = info_word(`MIN_GRANT_VALUE);
            end
            `OFF_MAX_LATENCY: begin
                read_word = info_word(`MAX_LATENCY_VALUE);
            end
            `OFF_LIMIT_0: begin
                read_word = s.limit_0;
            end
            `OFF_BASE_0: begin
                read_word = s.base_0;
            end
            `OFF_XLATE_0: begin
                read_word = s.xlate_0;
            end
            `OFF_LIMIT_1: begin
                read_word = s.limit_1;
            end
            `OFF_BASE_1: begin
                read_word = s.base_1;
            end
            `OFF_LIMIT_2: begin
                read_word = s.limit_2;
            end
            `OFF_BASE_2: begin
                read_word = s.base_2;
            end
            `OFF_XLATE_2: begin
                read_word = s.xlate_2;
            end
            `OFF_ROM_LIMIT: begin
                read_word = s.rom_limit;
            end
            `OFF_ROM_BASE: begin
                read_word = s.rom_base;
            end
            `OFF_ROM_XLATE: begin
                read_word = s.rom_xlate;
            end
            `OFF_OUT_IO_XLATE: begin
                read_word = s.out_io_xlate;
            end
            `OFF_OUT_MEM_XLATE: begin
                read_word = s.out_mem_xlate;
            end
            default: begin
                read_word = `ZERO_WORD;
            end
        endcase
    endfunction

    // result of one inbound or outbound address lookup
    typedef struct packed {
        logic        claim;
        logic        is_io;
        logic [1:0]  window;
        logic [31:0] addr;
    } lookup_t;

    // fixed priority settles overlapping windows; window 1 is never looked at
    function automatic lookup_t inbound_lookup(
        input state_t      s,
        input logic [31:0] addr
    );
        lookup_t r;
        r = '0;
        if (window_hit(addr, s.base_0, s.limit_0)) begin
            r.claim  = 1'h1;
            r.window = in_win0;
            r.addr   = translate(addr, s.xlate_0, s.limit_0);
        end else if (window_hit(addr, s.base_2, s.limit_2)) begin
            r.claim  = 1'h1;
            r.window = in_win2;
            r.addr   = translate(addr, s.xlate_2, s.limit_2);
        end else if (window_hit(addr, s.rom_base, s.rom_limit)) begin
            r.claim  = 1'h1;
            r.window = in_rom;
            r.addr   = translate(addr, s.rom_xlate, s.rom_limit);
        end
        inbound_lookup = r;
    endfunction

    function automatic lookup_t outbound_lookup(
        input state_t      s,
        input logic [31:0] addr
    );
        lookup_t r;
        r = '0;
        if (fixed_hit(addr, `OUT_IO_BASE, `OUT_IO_MASK)) begin
            r.claim = 1'h1;
            r.is_io = 1'h1;
            r.addr  = fixed_translate(addr, s.out_io_xlate, `OUT_IO_MASK);
        end else if (fixed_hit(addr, `OUT_MEM_BASE, `OUT_MEM_MASK)) begin
            r.claim = 1'h1;
            r.addr  = fixed_translate(addr, s.out_mem_xlate, `OUT_MEM_MASK);
        end
        outbound_lookup = r;
    endfunction

    always_comb begin
        lookup_t in_res;
        lookup_t out_res;
        in_res  = inbound_lookup(state_q, in_pci_addr);
        out_res = outbound_lookup(state_q, out_internal_addr);

        state_d = state_q;
        if (reg_write) begin
            state_d = apply_write(state_q, reg_addr, reg_wdata);
        end

        // read data stand one cycle and fall back to zero
        state_d.rdata = `ZERO_WORD;
        if (reg_read) begin
            state_d.rdata = read_word(state_q, reg_addr);
        end

        // inbound: window 1 is deliberately absent, it only reserves host space
        state_d.in_claim  = 1'h0;
        state_d.in_window = in_none;
        state_d.in_addr   = `ZERO_WORD;
        if (in_valid) begin
            state_d.in_claim  = in_res.claim;
            state_d.in_window = in_res.window;
            state_d.in_addr   = in_res.addr;
        end

        // outbound fixed windows
        state_d.out_claim = 1'h0;
        state_d.out_is_io = 1'h0;
        state_d.out_addr  = `ZERO_WORD;
        if (out_valid) begin
            state_d.out_claim = out_res.claim;
            state_d.out_is_io = out_res.is_io;
            state_d.out_addr  = out_res.addr;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata        = state_q.rdata;
    assign in_claim         = state_q.in_claim;
    assign in_window        = state_q.in_window;
    assign in_internal_addr = state_q.in_addr;
    assign out_claim        = state_q.out_claim;
    assign out_is_io        = state_q.out_is_io;
    assign out_pci_addr     = state_q.out_addr;

endmodule

//--- tb/translation_unit_sva.sv
// concurrent checks on the translation unit ports
`timescale 1ns/1ns
module translation_unit_sva (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        in_valid,
    input wire logic [31:0] in_pci_addr,
    input wire logic        in_claim,
    input wire logic [1:0]  in_window,
    input wire logic [31:0] in_internal_addr,
    input wire logic        out_valid,
    input wire logic [31:0] out_internal_addr,
    input wire logic        out_claim,
    input wire logic        out_is_io
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence io_req;
        out_valid && out_internal_addr[31:16] == 16'h9000;
    endsequence
    sequence mem_req;
        out_valid && out_internal_addr[31:26] == 6'h20;
    endsequence
    a_rdata_quiet: assert property (!$past(reg_read) |-> reg_rdata == 32'h0) else $error("rdata not idle");
    a_claim_cause: assert property (in_claim |-> $past(in_valid)) else $error("claim without request");
    a_idle_zero: assert property (!in_claim |-> in_window == 2'h0 && in_internal_addr == 32'h0)
        else $error("idle inbound outputs");
    a_win_code: assert property (in_claim |-> in_window != 2'h0) else $error("claim without window");
    a_in_offset: assert property (in_claim |-> in_internal_addr[11:0] == $past(in_pci_addr[11:0]))
        else $error("offset lost");
    a_io_claim: assert property (io_req |=> out_claim && out_is_io) else $error("io miss");
    a_mem_claim: assert property (mem_req |=> out_claim && !out_is_io) else $error("mem miss");
    a_out_cause: assert property (out_claim |-> $past(out_valid) && (out_is_io ?
        $past(out_internal_addr[31:16]) == 16'h9000 : $past(out_internal_addr[31:26]) == 6'h20))
        else $error("outbound claim outside window");
endmodule

//--- tb/far_side_agents.sv
// pci master and internal agent issuing one address phase per call
`timescale 1ns/1ns
module far_side_agents (
    input  wire logic        clock,
    output logic             in_valid = 1'h0,
    output logic [31:0]      in_pci_addr = 32'h0,
    output logic             out_valid = 1'h0,
    output logic [31:0]      out_internal_addr = 32'h0
);
    // released address lines flip so a stale value never matches by luck
    task automatic inbound(input logic [31:0] a);
        @(posedge clock);
        in_valid <= 1'h1;
        in_pci_addr <= a;
        @(posedge clock);
        in_valid <= 1'h0;
        in_pci_addr <= ~a;
    endtask
    task automatic outbound(input logic [31:0] a);
        @(posedge clock);
        out_valid <= 1'h1;
        out_internal_addr <= a;
        @(posedge clock);
        out_valid <= 1'h0;
        out_internal_addr <= ~a;
    endtask
endmodule

//--- tb/tb_translation_unit.sv
// self-checking bench for the translation unit
`timescale 1ns/1ns
`include "window_defs.svh"
module tb_translation_unit import window_pkg::*;;
    logic        clock = 1'h0, resetn = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, in_pci_addr, in_internal_addr, out_internal_addr, out_pci_addr;
    logic        in_valid, in_claim, out_valid, out_claim, out_is_io;
    logic [1:0]  in_window;
    int          errors = 0, n_tests = 0, cycles = 0;
    always #5 clock = ~clock;
    far_side_agents fs (.clock(clock), .in_valid(in_valid), .in_pci_addr(in_pci_addr), .out_valid(out_valid),
        .out_internal_addr(out_internal_addr));
    translation_unit dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .in_valid(in_valid),
        .in_pci_addr(in_pci_addr), .in_claim(in_claim), .in_window(in_window), .in_internal_addr(in_internal_addr),
        .out_valid(out_valid), .out_internal_addr(out_internal_addr), .out_claim(out_claim),
        .out_is_io(out_is_io), .out_pci_addr(out_pci_addr));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_write <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'h0;
        #1 chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask
    task automatic chk_in(input logic [31:0] a, input logic [1:0] w, input logic [31:0] ia);
        fs.inbound(a);
        #1 chk("in_claim", {31'h0, w != 2'h0}, {31'h0, in_claim});
        chk("in_window", {30'h0, w}, {30'h0, in_window});
        chk("in_internal_addr", ia, in_internal_addr);
    endtask
    task automatic chk_out(input logic [31:0] a, input logic c, input logic io, input logic [31:0] pa);
        fs.outbound(a);
        #1 chk("out_flags", {30'h0, c, io}, {30'h0, out_claim, out_is_io});
        chk("out_pci_addr", pa, out_pci_addr);
    endtask
    logic [7:0]  lim[3] = '{`OFF_LIMIT_0, `OFF_LIMIT_2, `OFF_ROM_LIMIT};
    logic [7:0]  bar[3] = '{`OFF_BASE_0, `OFF_BASE_2, `OFF_ROM_BASE};
    logic [7:0]  xlt[3] = '{`OFF_XLATE_0, `OFF_XLATE_2, `OFF_ROM_XLATE};
    logic [1:0]  code[3] = '{in_win0, in_win2, in_rom};
    // low translate bits are junk on purpose, rom entry stays aligned
    logic [31:0] xv[3] = '{32'h40012345, 32'h50054321, 32'h60000000};
    task automatic t_regs();
        rd(`OFF_MIN_GRANT, {24'h0, `MIN_GRANT_VALUE});
        rd(`OFF_MAX_LATENCY, {24'h0, `MAX_LATENCY_VALUE});
        rd(8'h3C, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(lim[i], 32'hFFF00000);
            wr(bar[i], 32'hFFFFFFFF);
            rd(bar[i], 32'hFFF00000);
        end
        wr(`OFF_BASE_1, 32'hFFFFFFFF);
        rd(`OFF_BASE_1, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_inbound();
        for (int i = 0; i < 3; i++) begin
            wr(bar[i], {4'(4'hA + i), 28'h0});
            wr(xlt[i], xv[i]);
            chk_in({4'(4'hA + i), 28'h00ABCDE}, code[i], (xv[i] & 32'hFFF00000) | 32'h000ABCDE);
        end
        chk_in(32'hD0000010, in_none, 32'h0);
        wr(`OFF_LIMIT_1, 32'hFFF00000);
        wr(`OFF_BASE_1, 32'hE0000000);
        chk_in(32'hE0000010, in_none, 32'h0);
        wr(`OFF_LIMIT_0, 32'h0);
        rd(`OFF_BASE_0, 32'h0);
        chk_in(32'hA00ABCDE, in_none, 32'h0);
        $display("test inbound done");
    endtask
    task automatic t_outbound();
        wr(`OFF_OUT_IO_XLATE, 32'h00010000);
        wr(`OFF_OUT_MEM_XLATE, 32'h20000000);
        chk_out(32'h9000FFFF, 1'h1, 1'h1, 32'h0001FFFF);
        chk_out(32'h83FFFFF0, 1'h1, 1'h0, 32'h23FFFFF0);
        chk_out(32'h90010000, 1'h0, 1'h0, 32'h0);
        chk_out(32'h84000000, 1'h0, 1'h0, 32'h0);
        $display("test outbound done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'h1;
        t_regs();
        t_inbound();
        t_outbound();
        conclude();
    end
endmodule
bind translation_unit translation_unit_sva sva_i (.clock(clock), .resetn(resetn), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .in_valid(in_valid), .in_pci_addr(in_pci_addr), .in_claim(in_claim),
    .in_window(in_window), .in_internal_addr(in_internal_addr), .out_valid(out_valid),
    .out_internal_addr(out_internal_addr), .out_claim(out_claim), .out_is_io(out_is_io));
